//--- common/cdms_pkg.sv
// constants and types for the downstream charge mode sequencer
package cdms_pkg;
  localparam int          NUM_PORTS      = 4;
  localparam int          ADDR_W         = 8;
  localparam int          DATA_W         = 8;
  // register offsets
  localparam logic [7:0]  REG_CHG_EN     = 8'h06;
  localparam logic [7:0]  REG_CTRL       = 8'h0A;
  localparam logic [7:0]  REG_SWEEP      = 8'h25;
  localparam logic [7:0]  REG_STRAP_STAT = 8'h40;
  localparam logic [7:0]  REG_PWR_STAT   = 8'h41;
  // field positions
  localparam int          CTRL_AUTO_DIS  = 1;
  localparam int          CTRL_HICUR     = 4;
  localparam int          SWEEP_FULL     = 0;
  localparam int          SWEEP_ALT_DIS  = 1;
  localparam int          ST_AUTO_N      = 4;
  localparam int          ST_FULL        = 5;
  localparam int          ST_PPP_N       = 6;
  localparam int          ST_GANG        = 7;
  localparam int          ST_SER_N       = 8;
  localparam int          ST_POL         = 9;
  localparam int          STRAP_W        = 10;
  // reset values
  localparam logic [7:0]  CHG_EN_RST     = 8'h00;
  localparam logic [7:0]  CTRL_RST       = 8'h12;
  localparam logic [7:0]  SWEEP_RST      = 8'h02;
  localparam logic [9:0]  STRAP_RST      = 10'h000;
  // timing
  localparam int          CLK_PERIOD_NS  = 10;
  localparam int          PWR_OFF_NS     = 1000;
  localparam int          PWR_OFF_CYC    = (PWR_OFF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          GAP_W          = 8;
  localparam longint      DCP_TIMEOUT_MS = 64'h7D0;
  localparam longint      DCP_TIMEOUT_CYC_L = DCP_TIMEOUT_MS * 64'hF4240 / CLK_PERIOD_NS;
  localparam int          TMR_W          = 28;
  // divider levels
  localparam logic [1:0]  LVL_OFF        = 2'h0;
  localparam logic [1:0]  LVL_LOW        = 2'h1;
  localparam logic [1:0]  LVL_MID        = 2'h2;
  localparam logic [1:0]  LVL_HIGH       = 2'h3;

  typedef enum logic [2:0] {
    CDMS_NONE,
    CDMS_CDP,
    CDMS_DCP,
    CDMS_DIV,
    CDMS_ALT,
    CDMS_GAP
  } cdms_mode_type;
endpackage : cdms_pkg

//--- core/cdms_charge_seq.sv
// per-port battery charging mode sequencer with register port and strap capture
`timescale 1ns/1ns
// Operation
// R01 - each port charges only if its enable bit, from field or strap, is set
// R02 - straps are captured on the cycle the global reset is released
// R03 - enabled port uses CDP when VBUS valid, hub configured, port powered
// R04 - upstream unconnected with charging enabled drives the port power on
// R05 - upstream unconnected, auto mode off: dedicated charging only
// R06 - auto mode enabled by low strap or low control bit 1
// R07 - divider and alternate modes only when unconnected and auto mode on
// R08 - auto mode starts in highest enabled divider level, stays without pull-up
// R09 - pull-up in divider: power off, go alternate or dedicated, power on
// R10 - pull-up in alternate: power off, go dedicated, power on
// R11 - dedicated mode stays while pull-up or data line voltage seen
// R12 - neither within two seconds: power off, back to divider, repeat
// R13 - full sweep tries every divider level before alternate or dedicated
// R14 - divider defaults to highest level; select bit picks lower level
// R15 - full sweep without alternate: high, mid, low, dedicated
// R16 - no sweep, no alternate: mid or high by select, then dedicated
// R17 - alternate mode, when enabled, sits just before dedicated mode
// R18 - without external memory, modes come from captured straps
// R19 - divider level places fixed level on the data lines
// R20 - reset source holds reset three ms after supplies stable
// R21 - two second timeout counts core clocks, restarts on dedicated entry
// R22 - charging enabled forces per-port power management, not ganged
module cdms_charge_seq #(
  parameter int unsigned DCP_TIMEOUT_CYC = int'(cdms_pkg::DCP_TIMEOUT_CYC_L)
) (
  // clock and reset
  input  wire logic                             CORE_CLK,
  input  wire logic                             RST,
  // register port
  input  wire logic [cdms_pkg::ADDR_W-1:0]      REG_ADDR,
  input  wire logic [cdms_pkg::DATA_W-1:0]      REG_WDATA,
  input  wire logic                             REG_WR,
  input  wire logic                             REG_RD,
  output logic      [cdms_pkg::DATA_W-1:0]      REG_RDATA,
  // straps
  input  wire logic [cdms_pkg::NUM_PORTS-1:0]   CHARGE_ENABLE_STRAPS,
  input  wire logic                             AUTO_SEQUENCE_STRAP_N,
  input  wire logic                             FULL_SWEEP_STRAP,
  input  wire logic                             PER_PORT_POWER_STRAP_N,
  input  wire logic                             GANGED_STRAP,
  input  wire logic                             SERIAL_HOST_SELECT_STRAP_N,
  input  wire logic                             POWER_ENABLE_POLARITY_STRAP,
  // hub status
  input  wire logic                             NVM_PRESENT,
  input  wire logic                             VBUS_VALID,
  input  wire logic                             HUB_CONFIGURED,
  input  wire logic [cdms_pkg::NUM_PORTS-1:0]   HOST_PORT_POWER,
  // port line detectors
  input  wire logic [cdms_pkg::NUM_PORTS-1:0]   DP_PULLUP,
  input  wire logic [cdms_pkg::NUM_PORTS-1:0]   DATA_LINE_VOLTAGE_DETECT,
  // port outputs
  output logic      [cdms_pkg::NUM_PORTS-1:0]   PORT_POWER_EN,
  output logic      [cdms_pkg::NUM_PORTS*3-1:0] PORT_MODE,
  output logic      [cdms_pkg::NUM_PORTS*2-1:0] DIVIDER_LEVEL,
  output logic      [cdms_pkg::NUM_PORTS-1:0]   DIVIDER_DRIVE,
  output logic                                  PER_PORT_POWER_MGMT,
  output logic                                  GANGED_POWER_MODE
);

  localparam int NP = cdms_pkg::NUM_PORTS;

  // all checks run on the core clock, idle in reset
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  // start level of the divider sweep
  function automatic logic [1:0] start_level(input logic full, input logic hicur);
    start_level = (full || hicur) ? cdms_pkg::LVL_HIGH : cdms_pkg::LVL_MID; // R14 R16
  endfunction : start_level

  // registers and strap capture
  logic [7:0]                 chg_en_r;
  logic [7:0]                 ctrl_r;
  logic [7:0]                 sweep_r;
  logic [cdms_pkg::STRAP_W-1:0] strap_r;
  logic                       rst_q_r;
  logic [7:0]                 rdata_r;
  logic                       ppm_r;
  logic                       gang_r;

  wire logic                  rel_w      = rst_q_r && !RST;
  wire logic [cdms_pkg::STRAP_W-1:0] strap_in_w = {POWER_ENABLE_POLARITY_STRAP,
                                                   SERIAL_HOST_SELECT_STRAP_N, GANGED_STRAP,
                                                   PER_PORT_POWER_STRAP_N, FULL_SWEEP_STRAP,
                                                   AUTO_SEQUENCE_STRAP_N, CHARGE_ENABLE_STRAPS};

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      rst_q_r <= 1'b1;
      strap_r <= cdms_pkg::STRAP_RST;
    end else begin
      rst_q_r <= 1'b0;
      if (rel_w) strap_r <= strap_in_w; // R02
    end
  end

  // effective configuration
  wire logic          use_regs_w = NVM_PRESENT; // R18
  wire logic [NP-1:0] chg_en_w   = use_regs_w ? chg_en_r[NP-1:0] : strap_r[NP-1:0]; // R01
  wire logic          auto_on_w  = use_regs_w ? !ctrl_r[cdms_pkg::CTRL_AUTO_DIS]
                                              : !strap_r[cdms_pkg::ST_AUTO_N]; // R06
  wire logic          full_w     = use_regs_w ? sweep_r[cdms_pkg::SWEEP_FULL]
                                              : strap_r[cdms_pkg::ST_FULL]; // R13
  wire logic          alt_en_w   = use_regs_w && !sweep_r[cdms_pkg::SWEEP_ALT_DIS]; // R17
  wire logic          hicur_w    = !use_regs_w || ctrl_r[cdms_pkg::CTRL_HICUR]; // R14
  wire logic          pol_w      = strap_r[cdms_pkg::ST_POL];
  wire logic [1:0]    first_lvl_w = start_level(full_w, hicur_w);

  // register port decode
  wire logic wr_chg_w   = REG_WR && (REG_ADDR == cdms_pkg::REG_CHG_EN);
  wire logic wr_ctrl_w  = REG_WR && (REG_ADDR == cdms_pkg::REG_CTRL);
  wire logic wr_sweep_w = REG_WR && (REG_ADDR == cdms_pkg::REG_SWEEP);
  logic [NP-1:0] pwr_r;
  wire logic [7:0] strap_stat_w = strap_r[7:0];
  wire logic [7:0] pwr_stat_w   = {{(8-NP){1'b0}}, pwr_r};
  wire logic [7:0] rd_mux_w =
    (REG_ADDR == cdms_pkg::REG_CHG_EN)     ? chg_en_r     :
    (REG_ADDR == cdms_pkg::REG_CTRL)       ? ctrl_r       :
    (REG_ADDR == cdms_pkg::REG_SWEEP)      ? sweep_r      :
    (REG_ADDR == cdms_pkg::REG_STRAP_STAT) ? strap_stat_w :
    (REG_ADDR == cdms_pkg::REG_PWR_STAT)   ? pwr_stat_w   : 8'h00;

  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      chg_en_r <= cdms_pkg::CHG_EN_RST;
      ctrl_r   <= cdms_pkg::CTRL_RST;
      sweep_r  <= cdms_pkg::SWEEP_RST;
      rdata_r  <= 8'h00;
    end else begin
      if (wr_chg_w)   chg_en_r <= {{(8-NP){1'b0}}, REG_WDATA[NP-1:0]};
      if (wr_ctrl_w)  ctrl_r   <= REG_WDATA;
      if (wr_sweep_w) sweep_r  <= REG_WDATA;
      rdata_r <= REG_RD ? rd_mux_w : 8'h00;
    end
  end
  assign REG_RDATA = rdata_r;

  // power management style
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ppm_r  <= 1'b0;
      gang_r <= 1'b0;
    end else begin
      ppm_r  <= (|chg_en_w) || !strap_r[cdms_pkg::ST_PPP_N]; // R22
      gang_r <= !(|chg_en_w) && strap_r[cdms_pkg::ST_GANG]; // R22
    end
  end
  assign PER_PORT_POWER_MGMT = ppm_r;
  assign GANGED_POWER_MODE   = gang_r;

  a_power_style: assert property ((|chg_en_w) |=> // R22
      PER_PORT_POWER_MGMT && !GANGED_POWER_MODE)
    else $error("charging without per-port power");

  // per-port state
  cdms_pkg::cdms_mode_type        mode_r  [NP];
  cdms_pkg::cdms_mode_type        tgt_r   [NP];
  logic [1:0]                     lvl_r   [NP];
  logic [1:0]                     tgtl_r  [NP];
  logic [cdms_pkg::GAP_W-1:0]     gap_r   [NP];
  logic [cdms_pkg::TMR_W-1:0]     tmr_r   [NP];
  logic [NP-1:0]                  run_w;

  for (genvar p = 0; p < NP; p++) begin : g_port
    cdms_pkg::cdms_mode_type    mode_nxt;
    cdms_pkg::cdms_mode_type    tgt_nxt;
    logic [1:0]                 lvl_nxt;
    logic [1:0]                 tgtl_nxt;
    logic [cdms_pkg::GAP_W-1:0] gap_nxt;
    logic [cdms_pkg::TMR_W-1:0] tmr_nxt;
    logic                       pwr_nxt;

    wire logic pull_w = DP_PULLUP[p];
    wire logic seen_w = DP_PULLUP[p] || DATA_LINE_VOLTAGE_DETECT[p];
    wire logic cdp_w  = VBUS_VALID && HUB_CONFIGURED && HOST_PORT_POWER[p];
    wire logic last_w = !full_w || (lvl_r[p] == cdms_pkg::LVL_LOW);
    wire logic tout_w = tmr_r[p] == cdms_pkg::TMR_W'(DCP_TIMEOUT_CYC - 1);
    assign run_w[p] = chg_en_w[p] && !VBUS_VALID && auto_on_w;

    always_comb begin
      mode_nxt = mode_r[p];
      tgt_nxt  = tgt_r[p];
      lvl_nxt  = lvl_r[p];
      tgtl_nxt = tgtl_r[p];
      gap_nxt  = gap_r[p];
      tmr_nxt  = tmr_r[p];
      if (!chg_en_w[p]) begin
        mode_nxt = cdms_pkg::CDMS_NONE; // R01
      end else if (VBUS_VALID) begin
        mode_nxt = cdp_w ? cdms_pkg::CDMS_CDP : cdms_pkg::CDMS_NONE; // R03
      end else if (!auto_on_w) begin
        mode_nxt = cdms_pkg::CDMS_DCP; // R05
      end else begin
        case (mode_r[p])
          cdms_pkg::CDMS_DIV: begin
            if (pull_w) begin
              mode_nxt = cdms_pkg::CDMS_GAP; // R09
              gap_nxt  = '0;
              if (!last_w) begin
                tgt_nxt  = cdms_pkg::CDMS_DIV; // R13 R15
                tgtl_nxt = lvl_r[p] - 2'h1;
              end else begin
                tgt_nxt  = alt_en_w ? cdms_pkg::CDMS_ALT : cdms_pkg::CDMS_DCP; // R17
                tgtl_nxt = cdms_pkg::LVL_OFF;
              end
            end
          end
          cdms_pkg::CDMS_ALT: begin
            if (pull_w) begin
              mode_nxt = cdms_pkg::CDMS_GAP; // R10
              gap_nxt  = '0;
              tgt_nxt  = cdms_pkg::CDMS_DCP;
              tgtl_nxt = cdms_pkg::LVL_OFF;
            end
          end
          cdms_pkg::CDMS_DCP: begin
            if (seen_w) begin
              tmr_nxt = '0; // R11
            end else if (tout_w) begin
              mode_nxt = cdms_pkg::CDMS_GAP; // R12
              gap_nxt  = '0;
              tgt_nxt  = cdms_pkg::CDMS_DIV;
              tgtl_nxt = first_lvl_w;
            end else begin
              tmr_nxt = tmr_r[p] + 1'b1; // R21
            end
          end
          cdms_pkg::CDMS_GAP: begin
            if (gap_r[p] == cdms_pkg::GAP_W'(cdms_pkg::PWR_OFF_CYC - 1)) begin
              mode_nxt = tgt_r[p];
              lvl_nxt  = tgtl_r[p];
              tmr_nxt  = '0; // R21
            end else begin
              gap_nxt = gap_r[p] + 1'b1;
            end
          end
          default: begin
            mode_nxt = cdms_pkg::CDMS_DIV; // R07 R08
            lvl_nxt  = first_lvl_w;
          end
        endcase
      end
      pwr_nxt = (mode_nxt == cdms_pkg::CDMS_CDP) || (mode_nxt == cdms_pkg::CDMS_DCP) ||
                (mode_nxt == cdms_pkg::CDMS_DIV) || (mode_nxt == cdms_pkg::CDMS_ALT); // R04
    end

    always_ff @(posedge CORE_CLK) begin
      if (RST) begin
        mode_r[p] <= cdms_pkg::CDMS_NONE;
        tgt_r[p]  <= cdms_pkg::CDMS_NONE;
        lvl_r[p]  <= cdms_pkg::LVL_OFF;
        tgtl_r[p] <= cdms_pkg::LVL_OFF;
        gap_r[p]  <= '0;
        tmr_r[p]  <= '0;
        pwr_r[p]  <= 1'b0;
      end else begin
        mode_r[p] <= mode_nxt;
        tgt_r[p]  <= tgt_nxt;
        lvl_r[p]  <= lvl_nxt;
        tgtl_r[p] <= tgtl_nxt;
        gap_r[p]  <= gap_nxt;
        tmr_r[p]  <= tmr_nxt;
        pwr_r[p]  <= pwr_nxt;
      end
    end

    wire logic div_w = mode_r[p] == cdms_pkg::CDMS_DIV;
    assign PORT_POWER_EN[p]        = pol_w ? pwr_r[p] : !pwr_r[p];
    assign PORT_MODE[3*p +: 3]     = mode_r[p];
    assign DIVIDER_LEVEL[2*p +: 2] = div_w ? lvl_r[p] : cdms_pkg::LVL_OFF;
    assign DIVIDER_DRIVE[p]        = div_w; // R19

    a_disabled_none: assert property (!chg_en_w[p] |=> mode_r[p] == cdms_pkg::CDMS_NONE) // R01
      else $error("disabled port not idle");
    a_cdp_entry: assert property (chg_en_w[p] && cdp_w |=> mode_r[p] == cdms_pkg::CDMS_CDP) // R03
      else $error("cdp not entered");
    a_unconn_power: assert property (!VBUS_VALID && chg_en_w[p] |=> // R04
        (mode_r[p] == cdms_pkg::CDMS_GAP) || pwr_r[p])
      else $error("port power not on");
    a_dcp_static: assert property (chg_en_w[p] && !VBUS_VALID && !auto_on_w // R05
        |=> mode_r[p] == cdms_pkg::CDMS_DCP)
      else $error("static dcp missing");
    a_custom_gate: assert property ((!chg_en_w[p] || VBUS_VALID || !auto_on_w) // R07
        |=> !div_w && mode_r[p] != cdms_pkg::CDMS_ALT)
      else $error("custom mode outside auto");
    a_div_hold: assert property (run_w[p] && div_w && !pull_w // R08
        |=> div_w && $stable(lvl_r[p]))
      else $error("divider left without pull-up");
    a_div_gap: assert property (run_w[p] && div_w && pull_w |=> // R09
        mode_r[p] == cdms_pkg::CDMS_GAP && !pwr_r[p])
      else $error("divider pull-up gap missing");
    a_alt_gap: assert property (run_w[p] && mode_r[p] == cdms_pkg::CDMS_ALT && pull_w |=> // R10
        mode_r[p] == cdms_pkg::CDMS_GAP && tgt_r[p] == cdms_pkg::CDMS_DCP)
      else $error("alternate pull-up gap wrong");
    a_dcp_hold: assert property (run_w[p] && mode_r[p] == cdms_pkg::CDMS_DCP && seen_w // R11
        |=> mode_r[p] == cdms_pkg::CDMS_DCP && tmr_r[p] == '0)
      else $error("dcp left while detected");
    a_dcp_timeout: assert property (run_w[p] && mode_r[p] == cdms_pkg::CDMS_DCP && !seen_w && // R12
        tout_w |=> mode_r[p] == cdms_pkg::CDMS_GAP && tgt_r[p] == cdms_pkg::CDMS_DIV)
      else $error("dcp timeout not taken");
    a_gap_len: assert property (mode_r[p] == cdms_pkg::CDMS_GAP |-> // R09
        gap_r[p] < cdms_pkg::GAP_W'(cdms_pkg::PWR_OFF_CYC) && !pwr_r[p])
      else $error("power-off gap too long");
    a_sweep_step: assert property (run_w[p] && full_w && div_w && pull_w && // R13
        lvl_r[p] == cdms_pkg::LVL_HIGH |=> tgtl_r[p] == cdms_pkg::LVL_MID)
      else $error("sweep skipped a level");

    // sweep start, level, order and resume checks, and cdp gating check
    a_start_level: assert property (run_w[p] && // R08 R14 R16
        !(mode_r[p] inside {cdms_pkg::CDMS_DIV, cdms_pkg::CDMS_ALT, cdms_pkg::CDMS_DCP,
        cdms_pkg::CDMS_GAP}) |=> div_w && lvl_r[p] == $past(first_lvl_w))
      else $error("sweep start level wrong");
    a_level_nonzero: assert property (div_w |-> lvl_r[p] != cdms_pkg::LVL_OFF) // R19
      else $error("divider drive without level");
    a_alt_skip: assert property (run_w[p] && !alt_en_w && div_w && pull_w && last_w |=> // R15
        tgt_r[p] == cdms_pkg::CDMS_DCP)
      else $error("disabled alternate not skipped");
    a_gap_resume: assert property (run_w[p] && mode_r[p] == cdms_pkg::CDMS_GAP && // R09
        gap_r[p] == cdms_pkg::GAP_W'(cdms_pkg::PWR_OFF_CYC - 1) |=>
        mode_r[p] == $past(tgt_r[p]) && pwr_r[p])
      else $error("gap did not resume target");
    a_cdp_none: assert property (VBUS_VALID && !cdp_w |=> // R03
        mode_r[p] == cdms_pkg::CDMS_NONE && !pwr_r[p])
      else $error("cdp without host power");
    c_cdp: cover property (mode_r[p] == cdms_pkg::CDMS_CDP);
    c_alt: cover property (mode_r[p] == cdms_pkg::CDMS_ALT);
    c_timeout: cover property (mode_r[p] == cdms_pkg::CDMS_DCP ##1
        mode_r[p] == cdms_pkg::CDMS_GAP);
    c_sweep_low: cover property (div_w && lvl_r[p] == cdms_pkg::LVL_LOW);
    c_gap_alt: cover property (mode_r[p] == cdms_pkg::CDMS_GAP ##1
        mode_r[p] == cdms_pkg::CDMS_ALT);
  end

  a_strap_take: assert property (@(posedge CORE_CLK) disable iff (RST) // R02
      rel_w |=> strap_r == $past(strap_in_w))
    else $error("straps not captured at release");
  a_rdata_idle: assert property (@(posedge CORE_CLK) disable iff (RST) // read data returns to zero the cycle after no read
      !REG_RD |=> REG_RDATA == 8'h00)
    else $error("read data without read");

endmodule : cdms_charge_seq

//--- verification/cdms_charge_seq_tb.sv
// self-checking bench for the downstream charge mode sequencer
`timescale 1ns/1ns
module cdms_charge_seq_tb;
  localparam int TMO = 50;
  logic        clk, rst, wr, rd, nvm, vbus, hcfg, ppm, gpm, slow;
  logic [7:0]  addr, wdata, rdata, lvl;
  logic [9:0]  pins, cap;
  logic [3:0]  hpp, dpu, vdet, pwr, drive, rej, acc;
  logic [11:0] mode;
  logic [31:0] lfsr;
  logic [4:0]  seq[$];
  int          bad_count, check_count, n, p;

  cdms_charge_seq #(.DCP_TIMEOUT_CYC(TMO)) cdms_charge_seq_i (
    .CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CHARGE_ENABLE_STRAPS(pins[3:0]),
    .AUTO_SEQUENCE_STRAP_N(pins[4]), .FULL_SWEEP_STRAP(pins[5]),
    .PER_PORT_POWER_STRAP_N(pins[6]), .GANGED_STRAP(pins[7]),
    .SERIAL_HOST_SELECT_STRAP_N(pins[8]), .POWER_ENABLE_POLARITY_STRAP(pins[9]),
    .NVM_PRESENT(nvm), .VBUS_VALID(vbus), .HUB_CONFIGURED(hcfg), .HOST_PORT_POWER(hpp),
    .DP_PULLUP(dpu), .DATA_LINE_VOLTAGE_DETECT(vdet), .PORT_POWER_EN(pwr),
    .PORT_MODE(mode), .DIVIDER_LEVEL(lvl), .DIVIDER_DRIVE(drive),
    .PER_PORT_POWER_MGMT(ppm), .GANGED_POWER_MODE(gpm));

  cdms_port_device cdms_port_device_i (.clk(clk), .rst(rst), .pwr_en(pwr), .mode(mode),
    .pol(cap[9]), .reject(rej), .accept(acc), .slow(slow), .dp_pullup(dpu), .vdet(vdet));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] nxt(logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : nxt

  // expected non-gap modes of one sweep, as {mode, level}
  function automatic void build(logic hi, logic full, logic altdis);
    seq = {};
    if (full) for (int l = 3; l > 0; l--) seq.push_back({cdms_pkg::CDMS_DIV, 2'(l)});
    else seq.push_back({cdms_pkg::CDMS_DIV, hi ? cdms_pkg::LVL_HIGH : cdms_pkg::LVL_MID});
    if (!altdis) seq.push_back({cdms_pkg::CDMS_ALT, cdms_pkg::LVL_OFF});
    seq.push_back({cdms_pkg::CDMS_DCP, cdms_pkg::LVL_OFF});
  endfunction : build

  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : check

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic step(int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : step

  task automatic reg_wr(logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr

  task automatic reg_rd(logic [7:0] a, logic [7:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check("rdata", rdata, e);
  endtask : reg_rd

  task automatic wait_while(logic [2:0] m, int lim);
    n = 0;
    while (mode[3*p+:3] === m && n < lim) begin
      step(1);
      n++;
    end
  endtask : wait_while

  // straps move away right after capture
  task automatic do_reset(logic [9:0] st, logic nv);
    @(posedge clk);
    rst <= 1'b1;
    pins <= st;
    nvm <= nv;
    cap = st;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    pins <= ~st;
    #1;
  endtask : do_reset

  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    nvm = 1'b1;
    vbus = 1'b0;
    hcfg = 1'b0;
    hpp = 4'h0;
    rej = 4'hF;
    acc = 4'h0;
    slow = 1'b0;
    pins = 10'h000;
    cap = 10'h000;
    bad_count = 0;
    check_count = 0;
    lfsr = 32'h7FEB;
    lfsr = nxt(lfsr);
    do_reset(lfsr[9:0], 1'b1);
    reg_rd(8'h06, 8'h00);
    reg_rd(8'h0A, 8'h12);
    reg_rd(8'h25, 8'h02);
    reg_rd(8'h40, cap[7:0]);
    check("ppm", ppm, !cap[6]);
    check("gpm", gpm, cap[7]);
    reg_wr(8'h3F, 8'hFF);
    reg_wr(8'h06, 8'hFF);
    reg_rd(8'h06, 8'h0F);
    reg_rd(8'h3F, 8'h00);
    check("ppm_on", ppm, 1'b1);
    check("gpm_off", gpm, 1'b0);
    check("dcp_only", mode, 12'h492);
    check("dcp_pwr", pwr, {4{cap[9]}});
    check("no_div", drive, 4'h0);
    $display("test registers done");
    lfsr = nxt(lfsr);
    @(posedge clk);
    vbus <= 1'b1;
    hcfg <= 1'b1;
    hpp <= 4'hF;
    reg_wr(8'h06, {4'h0, lfsr[3:0]});
    step(2);
    for (int i = 0; i < 4; i++) begin
      check("cdp", mode[3*i+:3], lfsr[i] ? cdms_pkg::CDMS_CDP : cdms_pkg::CDMS_NONE);
    end
    @(posedge clk);
    hpp <= 4'h5;
    step(2);
    for (int i = 0; i < 4; i++) begin
      check("cdp_gate", mode[3*i+:3], (lfsr[i] && i[0] == 1'b0) ? cdms_pkg::CDMS_CDP
            : cdms_pkg::CDMS_NONE);
    end
    @(posedge clk);
    vbus <= 1'b0;
    step(2);
    for (int i = 0; i < 4; i++) begin
      check("dcp", mode[3*i+:3], lfsr[i] ? cdms_pkg::CDMS_DCP : cdms_pkg::CDMS_NONE);
    end
    $display("test upstream done");
    for (int c = 0; c < 9; c++) begin
      lfsr = nxt(lfsr);
      slow = lfsr[12];
      acc = 4'hF;
      p = int'(lfsr[11:10]);
      if (c < 8) begin
        do_reset(lfsr[9:0], 1'b1);
        reg_wr(8'h25, {6'h00, c[2], c[1]});
        reg_wr(8'h0A, {3'h0, c[0], 4'h0});
        // enable last so each port starts its sweep from idle
        reg_wr(8'h06, 8'h0F);
        build(c[0], c[1], c[2]);
      end else begin
        do_reset({lfsr[9:8], 2'h0, lfsr[5], 1'b0, 4'hF}, 1'b0);
        build(1'b1, cap[5], 1'b1);
      end
      step(2);
      foreach (seq[i]) begin
        check("mode", {mode[3*p+:3], lvl[2*p+:2]}, seq[i]);
        check("power", pwr[p], cap[9]);
        check("drive", drive[p], seq[i][4:2] == cdms_pkg::CDMS_DIV);
        if (i < seq.size() - 1) begin
          wait_while(seq[i][4:2], 80);
          check("gap", {mode[3*p+:3], pwr[p]}, {cdms_pkg::CDMS_GAP, !cap[9]});
          wait_while(cdms_pkg::CDMS_GAP, 300);
          check("gap_len", n >= cdms_pkg::PWR_OFF_CYC - 3 && n <= cdms_pkg::PWR_OFF_CYC + 1, 1);
        end
      end
      step(TMO + 20);
      check("dcp_hold", mode[3*p+:3], cdms_pkg::CDMS_DCP);
      acc[p] = 1'b0;
      wait_while(cdms_pkg::CDMS_DCP, TMO + 20);
      check("dcp_tmo", n >= TMO - 2 && n <= TMO + 2, 1);
      check("tmo_gap", {mode[3*p+:3], pwr[p]}, {cdms_pkg::CDMS_GAP, !cap[9]});
      wait_while(cdms_pkg::CDMS_GAP, 300);
      check("restart", {mode[3*p+:3], lvl[2*p+:2]}, seq[0]);
      $display("test auto case %0d done", c);
    end
    end_of_test();
  end
endmodule : cdms_charge_seq_tb

//--- verification/cdms_port_device.sv
// behavioural portable device attached to each downstream port
`timescale 1ns/1ns
module cdms_port_device (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // hub side of the port
  input  wire logic [3:0]  pwr_en,
  input  wire logic [11:0] mode,
  input  wire logic        pol,
  // behaviour chosen by the bench
  input  wire logic [3:0]  reject,
  input  wire logic [3:0]  accept,
  input  wire logic        slow,
  // line detector results seen by the hub
  output logic      [3:0]  dp_pullup,
  output logic      [3:0]  vdet
);
  logic [5:0] cnt_r [4];

  // time spent powered in divider or alternate signature
  always_ff @(posedge clk) begin
    for (int p = 0; p < 4; p++) begin
      if (rst || pwr_en[p] != pol || !(mode[3*p+:3] inside {3'h3, 3'h4}) || !reject[p]) begin
        cnt_r[p] <= 6'h00;
      end else if (cnt_r[p] != 6'h3F) begin
        cnt_r[p] <= cnt_r[p] + 6'h01;
      end
    end
  end

  // pull-up once the signature is refused; released lines read low
  for (genvar p = 0; p < 4; p++) begin : g_line
    assign dp_pullup[p] = cnt_r[p] >= (slow ? 6'h28 : 6'h08);
    assign vdet[p]      = pwr_en[p] == pol && mode[3*p+:3] == 3'h2 && accept[p];
  end
endmodule : cdms_port_device
